// >>> hdl/twm_pkg.sv
/*
 two-wire master port: register map, field positions, reset values,
 state encoding and carriers shared by the design.
 assumes a cpu register port with 8-bit data and 3-bit address.
*/
package twm_pkg;
    // register offsets
    localparam logic [2:0] ADDR_BUF = 3'h0;
    localparam logic [2:0] ADDR_STAT = 3'h1;
    localparam logic [2:0] ADDR_CTRL2 = 3'h2;
    localparam logic [2:0] ADDR_BAUD = 3'h3;
    localparam logic [2:0] ADDR_IRQ = 3'h4;
    localparam logic [2:0] ADDR_MASK = 3'h5;
    localparam logic [2:0] ADDR_CTRL1 = 3'h6;
    // status register bits
    localparam int STAT_FULL = 0;
    localparam int STAT_OVF = 1;
    localparam int STAT_WRITE_COLLISION_FLAG = 2;
    // control register 2 bits
    localparam int CTRL2_RCV = 3;
    localparam int CTRL2_ACKEN = 4;
    localparam int CTRL2_ACKDATA = 5;
    localparam int CTRL2_ACKSTAT = 6;
    // control register 1 bits
    localparam int CTRL1_ENABLE = 0;
    localparam int CTRL1_SLEEP = 1;
    // interrupt status bits
    localparam int IRQ_PORT = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_WRITE_COLLISION_FLAG = 2;
    localparam int IRQ_WIDTH = 3;
    // widths and reset values
    localparam int BAUD_WIDTH = 7;
    localparam int BYTE_BITS = 8;
    localparam logic [6:0] BAUD_RESET = 7'h09;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TX = 3'b001,
        ST_RX = 3'b011,
        ST_ACK = 3'b010
    } twm_state_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } twm_req_type;

    typedef struct packed {
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
    } twm_pins_type;
endpackage

// >>> hdl/twm_master.sv
/*
 two-wire bus master byte engine: transmit, receive, acknowledge,
 clock arbitration, flags and interrupt.
 assumes bus pins are open drain with external pull-ups and that
 scl and sda inputs are already synchronous to sys_clk.
*/
// The address map and the plain strobed port were decided locally.
// Summary of operation
// - writing buffer in transmit sets full; cleared after eight bits shifted
// - buffer write during shifting sets collision flag, write discarded
// - collision flag stays until software clears it
// - transmit: ack status cleared on slave ack, set on no ack
// - receive: each generator rollover toggles clock; data bit sampled once clock seen high
// - after eighth clock: copy byte, flags, stop generator, clock low
// - reading buffer in receive clears full flag
// - setting ack enable after a byte starts ack sequence
// - overflow set when byte completes while full still set
// - generator suspended while released clock not yet sampled high
// - on clock high generator reloads baud value and counts
// - in sleep reception continues; wake on completed byte if enabled
// - reset disables port and aborts transfer
// - transmit: clock low one rollover per bit, data after falling
`timescale 1ns/10ps
`default_nettype none
module twm_master
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire twm_pkg::twm_req_type req,
    output logic [7:0] rdata,
    // bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output twm_pkg::twm_pins_type pins,
    // system
    output logic irq,
    output logic wake
);
    twm_pkg::twm_state_type state;
    logic [6:0] baudReload;
    logic [6:0] baudCount;
    logic [7:0] shiftReg;
    logic [7:0] transferBuf;
    logic [3:0] bitCount;
    logic sclHigh;
    logic waitHigh;
    logic bufferFull;
    logic overflow;
    logic writeCollision;
    logic ackStatus;
    logic ackData;
    logic portEnable;
    logic sleepMode;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic rollover;
    logic busy;
    logic wrBuf;
    logic rdBuf;
    logic byteDone;
    logic ackDone;
    logic rxStart;
    logic ackStart;
    logic [2:0] next_irqStatus;

    assign busy = (state != twm_pkg::ST_IDLE);
    assign wrBuf = req.write && req.addr == twm_pkg::ADDR_BUF;
    assign rdBuf = req.read && req.addr == twm_pkg::ADDR_BUF;
    assign rollover = busy && !waitHigh && baudCount == 7'h00;
    assign rxStart = portEnable && !busy && req.write &&
        req.addr == twm_pkg::ADDR_CTRL2 &&
        req.wdata[twm_pkg::CTRL2_RCV];
    assign ackStart = portEnable && !busy && req.write &&
        req.addr == twm_pkg::ADDR_CTRL2 &&
        req.wdata[twm_pkg::CTRL2_ACKEN] &&
        !req.wdata[twm_pkg::CTRL2_RCV];
    // fall that completes the eighth (rx) or ninth (tx) clock
    assign byteDone = rollover && sclHigh && (
        (state == twm_pkg::ST_RX &&
        (bitCount + 4'h1) == twm_pkg::BIT_LAST) ||
        (state == twm_pkg::ST_TX &&
        (bitCount + 4'h1) == twm_pkg::BIT_ACK));
    assign ackDone = rollover && sclHigh && state == twm_pkg::ST_ACK;

    // configuration registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            baudReload <= twm_pkg::BAUD_RESET;
            portEnable <= 1'b0;
            sleepMode <= 1'b0;
            ackData <= 1'b0;
            irqMask <= 3'h0;
        end
        else if (req.write)
        begin
            unique case (req.addr)
                twm_pkg::ADDR_BAUD: baudReload <= req.wdata[6:0];
                twm_pkg::ADDR_MASK: irqMask <= req.wdata[2:0];
                twm_pkg::ADDR_CTRL2:
                    ackData <= req.wdata[twm_pkg::CTRL2_ACKDATA];
                twm_pkg::ADDR_CTRL1:
                begin
                    portEnable <= req.wdata[twm_pkg::CTRL1_ENABLE];
                    sleepMode <= req.wdata[twm_pkg::CTRL1_SLEEP];
                end
                default: ;
            endcase
        end
    end

    // sequencer and shifting
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= twm_pkg::ST_IDLE;
            shiftReg <= 8'h00;
            bitCount <= 4'h0;
            sclHigh <= 1'b0;
            waitHigh <= 1'b0;
            baudCount <= 7'h00;
        end
        else if (!portEnable)
        begin
            state <= twm_pkg::ST_IDLE;
            sclHigh <= 1'b0;
            waitHigh <= 1'b0;
        end
        else if (!busy)
        begin
            bitCount <= 4'h0;
            sclHigh <= 1'b0;
            waitHigh <= 1'b0;
            baudCount <= baudReload;
            if (wrBuf)
            begin
                state <= twm_pkg::ST_TX;
                shiftReg <= req.wdata;
            end
            else if (rxStart)
                state <= twm_pkg::ST_RX;
            else if (ackStart)
                state <= twm_pkg::ST_ACK;
        end
        else if (waitHigh)
        begin
            // a stretching slave holds scl low; no counting meanwhile
            if (sclIn)
            begin
                waitHigh <= 1'b0;
                baudCount <= baudReload;
                // sample only once scl is seen high, after any stretch
                if (state == twm_pkg::ST_RX)
                    shiftReg <= {shiftReg[6:0], sdaIn};
            end
        end
        else if (!rollover)
            baudCount <= baudCount - 7'h01;
        else
        begin
            baudCount <= baudReload;
            sclHigh <= !sclHigh;
            if (!sclHigh)
                waitHigh <= 1'b1;
            else
            begin
                bitCount <= bitCount + 4'h1;
                if (state == twm_pkg::ST_TX && bitCount < twm_pkg::BIT_LAST)
                    shiftReg <= {shiftReg[6:0], 1'b0};
                if (byteDone || ackDone)
                    state <= twm_pkg::ST_IDLE;
            end
        end
    end

    // buffer, full flag and acknowledge status
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            transferBuf <= 8'h00;
            bufferFull <= 1'b0;
            ackStatus <= 1'b0;
        end
        else
        begin
            if (wrBuf && !busy && portEnable)
            begin
                transferBuf <= req.wdata;
                bufferFull <= 1'b1;
            end
            else if (state == twm_pkg::ST_RX && byteDone)
            begin
                transferBuf <= shiftReg;
                bufferFull <= 1'b1;
            end
            else if (state == twm_pkg::ST_TX && rollover && sclHigh &&
                bitCount == 4'h7)
                bufferFull <= 1'b0;
            else if (rdBuf)
                bufferFull <= 1'b0;
            // read as the ninth clock falls, while the slave still drives
            if (state == twm_pkg::ST_TX && rollover && sclHigh &&
                bitCount == twm_pkg::BIT_LAST)
                ackStatus <= sdaIn;
        end
    end

    // sticky flags: hardware set wins over software clear
    always_comb
    begin
        next_irqStatus = irqStatus;
        if (req.write && req.addr == twm_pkg::ADDR_IRQ)
            next_irqStatus = irqStatus & ~req.wdata[2:0];
        if (byteDone || ackDone)
            next_irqStatus[twm_pkg::IRQ_PORT] = 1'b1;
        if (state == twm_pkg::ST_RX && byteDone && bufferFull && !rdBuf)
            next_irqStatus[twm_pkg::IRQ_OVF] = 1'b1;
        if (wrBuf && busy)
            next_irqStatus[twm_pkg::IRQ_WRITE_COLLISION_FLAG] = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqStatus <= 3'h0;
            overflow <= 1'b0;
            writeCollision <= 1'b0;
        end
        else
        begin
            irqStatus <= next_irqStatus;
            if (state == twm_pkg::ST_RX && byteDone && bufferFull && !rdBuf)
                overflow <= 1'b1;
            else if (req.write && req.addr == twm_pkg::ADDR_STAT &&
                !req.wdata[twm_pkg::STAT_OVF])
                overflow <= 1'b0;
            if (wrBuf && busy)
                writeCollision <= 1'b1;
            else if (req.write && req.addr == twm_pkg::ADDR_STAT &&
                !req.wdata[twm_pkg::STAT_WRITE_COLLISION_FLAG])
                writeCollision <= 1'b0;
        end
    end

    // pins, read data and interrupt outputs, all registered
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pins <= '0;
            rdata <= 8'h00;
            irq <= 1'b0;
            wake <= 1'b0;
        end
        else
        begin
            pins.sclOut <= 1'b0;
            pins.sdaOut <= 1'b0;
            // scl is pulled low whenever enabled and not released
            pins.sclOe <= portEnable && !sclHigh;
            unique case (state)
                twm_pkg::ST_TX:
                    pins.sdaOe <= bitCount < twm_pkg::BIT_LAST &&
                        !shiftReg[7];
                twm_pkg::ST_ACK: pins.sdaOe <= !ackData;
                default: pins.sdaOe <= 1'b0;
            endcase
            irq <= |(next_irqStatus & irqMask);
            wake <= sleepMode && next_irqStatus[twm_pkg::IRQ_PORT] &&
                irqMask[twm_pkg::IRQ_PORT];
            rdata <= 8'h00;
            if (req.read)
            begin
                unique case (req.addr)
                    twm_pkg::ADDR_BUF: rdata <= transferBuf;
                    twm_pkg::ADDR_STAT: rdata <= {5'h00, writeCollision,
                        overflow, bufferFull};
                    twm_pkg::ADDR_CTRL2: rdata <= {1'b0, ackStatus,
                        ackData, state == twm_pkg::ST_ACK,
                        state == twm_pkg::ST_RX, 3'h0};
                    twm_pkg::ADDR_BAUD: rdata <= {1'b0, baudReload};
                    twm_pkg::ADDR_IRQ: rdata <= {5'h00, irqStatus};
                    twm_pkg::ADDR_MASK: rdata <= {5'h00, irqMask};
                    twm_pkg::ADDR_CTRL1: rdata <= {6'h00, sleepMode,
                        portEnable};
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

    a_rx_enable_idle: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        busy && req.write && req.addr == twm_pkg::ADDR_CTRL2 |=>
        $stable(state) || state == twm_pkg::ST_IDLE)
        else $error("receive enable taken while busy");
    a_write_collision_flag_sticky: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        writeCollision && !(req.write && req.addr == twm_pkg::ADDR_STAT)
        |=> writeCollision)
        else $error("collision flag cleared by hardware");
    a_write_collision_flag_discard: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        wrBuf && busy && !(state == twm_pkg::ST_RX && byteDone) |=>
        writeCollision && $stable(transferBuf))
        else $error("colliding write not discarded");
    a_rx_byte_load: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        state == twm_pkg::ST_RX && byteDone |=>
        state == twm_pkg::ST_IDLE && bufferFull &&
        transferBuf == $past(shiftReg) && irqStatus[twm_pkg::IRQ_PORT])
        else $error("received byte not completed");
    a_read_clears_full: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        rdBuf && !busy && !wrBuf |=> !bufferFull)
        else $error("buffer read did not clear full");
    a_overflow_set: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        state == twm_pkg::ST_RX && byteDone && bufferFull && !rdBuf
        |=> overflow)
        else $error("overflow not flagged");
    a_stretch_hold: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        waitHigh && !sclIn && portEnable |=> $stable(baudCount))
        else $error("generator counted during stretch");
    a_reload_high: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        waitHigh && sclIn && portEnable && busy |=>
        baudCount == $past(baudReload) && !waitHigh)
        else $error("generator not reloaded on clock high");
    a_ack_status: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        state == twm_pkg::ST_TX && rollover && sclHigh &&
        bitCount == twm_pkg::BIT_LAST |=> ackStatus == $past(sdaIn))
        else $error("ack status not captured");
    a_port_irq_sticky: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        irqStatus[twm_pkg::IRQ_PORT] && !req.write |=>
        irqStatus[twm_pkg::IRQ_PORT])
        else $error("port interrupt flag lost");
endmodule
`default_nettype wire

// >>> dv/twm_slave_model.sv
/*
 behavioural slave on the two-wire bus, no address matching: answers master
 bytes with ack or nack, serves a byte on master reads, can stretch scl.
 assumes scl and sda are the resolved open-drain wire levels.
*/
`timescale 1ns/10ps
`default_nettype none
module twm_slave_model
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bus wires
    input wire logic scl,
    input wire logic sda,
    output logic sclPull,
    output logic sdaPull,
    // test control
    input wire logic rxMode,
    input wire logic nack,
    input wire logic [7:0] txByte,
    input wire logic [7:0] stretch,
    input wire logic arm,
    output logic [7:0] gotByte
);
    logic sclQ;
    logic [3:0] bitCnt;
    logic [7:0] stretchCnt;
    // stretching only after the master's own fall, never mid-high
    assign sclPull = (stretchCnt != 8'h00);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclQ <= 1'b1;
            bitCnt <= 4'h0;
            stretchCnt <= 8'h00;
            sdaPull <= 1'b0;
            gotByte <= 8'h00;
        end
        else
        begin
            sclQ <= scl;
            if (stretchCnt != 8'h00)
                stretchCnt <= stretchCnt - 8'h01;
            if (arm)
            begin
                bitCnt <= 4'h0;
                sdaPull <= rxMode & ~txByte[7];
            end
            else if (sclQ & ~scl)
            begin
                stretchCnt <= stretch;
                if (rxMode)
                    sdaPull <= (bitCnt < 4'h8) & ~txByte[3'h7 - bitCnt[2:0]];
                else
                    sdaPull <= (bitCnt == 4'h8) & ~nack;
            end
            else if (~sclQ & scl)
            begin
                bitCnt <= bitCnt + 4'h1;
                if (!rxMode && bitCnt < 4'h8)
                    gotByte <= {gotByte[6:0], sda};
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb_two_wire_master_rx_status.sv
/*
 self-checking bench for the two-wire master: register tasks, bus
 monitor and directed transfers against the slave model.
 assumes pull-ups on both wires and a 100 MHz sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_two_wire_master_rx_status;
    logic sys_clk = 1'b0;
    logic reset_n;
    twm_pkg::twm_req_type req;
    twm_pkg::twm_pins_type pins;
    logic [7:0] rdata;
    logic irq;
    logic wake;
    wire logic scl;
    wire logic sda;
    logic sclPull;
    logic sdaPull;
    logic rxMode;
    logic nack;
    logic [7:0] txByte;
    logic [7:0] stretch;
    logic arm;
    logic [7:0] gotByte;
    logic [7:0] v;
    logic [7:0] minHigh;
    logic wakeSeen;
    logic [7:0] highRun = 8'h00;
    logic sclQ = 1'b1;
    logic lastSda = 1'b1;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    assign scl = ~(pins.sclOe | sclPull);
    assign sda = ~(pins.sdaOe | sdaPull);
    twm_master twm_master_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .req(req), .rdata(rdata), .sclIn(scl), .sdaIn(sda), .pins(pins),
        .irq(irq), .wake(wake));
    twm_slave_model twm_slave_model_inst (.sys_clk(sys_clk),
        .reset_n(reset_n), .scl(scl), .sda(sda), .sclPull(sclPull),
        .sdaPull(sdaPull), .rxMode(rxMode), .nack(nack), .txByte(txByte),
        .stretch(stretch), .arm(arm), .gotByte(gotByte));
    // shortest scl high time and last bit sampled at a rise
    always @(posedge sys_clk)
    begin
        sclQ <= scl;
        highRun <= scl ? highRun + 8'h01 : 8'h00;
        if (sclQ & ~scl && highRun < minHigh)
            minHigh <= highRun;
        if (~sclQ & scl)
            lastSda <= sda;
    end
    task automatic tally_and_finish();
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            $display("ERROR %0t run timed out", $time);
            tally_and_finish();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req.addr <= a;
        req.wdata <= d;
        req.write <= 1'b1;
        @(posedge sys_clk);
        req.write <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req.addr <= a;
        req.read <= 1'b1;
        @(posedge sys_clk);
        req.read <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic do_reset();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask
    task automatic setup(input logic rx, input logic nk,
        input logic [7:0] b, input logic [7:0] st);
        @(posedge sys_clk);
        rxMode <= rx;
        nack <= nk;
        txByte <= b;
        stretch <= st;
        arm <= 1'b1;
        minHigh <= 8'hff;
        @(posedge sys_clk);
        arm <= 1'b0;
    endtask
    // bounded wait; a hang here counts against the run
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        wakeSeen = wake;
        check({7'h00, irq}, 8'h01);
        wr(twm_pkg::ADDR_IRQ, 8'h07);
    endtask
    initial
    begin
        reset_n = 1'b0;
        req = '0;
        rxMode = 1'b0;
        nack = 1'b0;
        txByte = 8'h00;
        stretch = 8'h00;
        arm = 1'b0;
        minHigh = 8'hff;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(twm_pkg::ADDR_BAUD, v);
        check(v, {1'b0, twm_pkg::BAUD_RESET});
        check({7'h00, pins.sclOe}, 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7, v);
        check(v, 8'h00);
        // only the port flag reaches irq; collisions stay masked
        wr(twm_pkg::ADDR_MASK, 8'h01);
        wr(twm_pkg::ADDR_BAUD, 8'h01);
        wr(twm_pkg::ADDR_CTRL1, 8'h01);
        setup(1'b0, 1'b0, 8'h00, 8'h06);
        wr(twm_pkg::ADDR_BUF, 8'ha5);
        rd(twm_pkg::ADDR_STAT, v);
        check(v, 8'h01);
        check({6'h00, pins.sclOut, pins.sdaOut}, 8'h00);
        wr(twm_pkg::ADDR_BUF, 8'h3c);
        #1 check({7'h00, irq}, 8'h00);
        rd(twm_pkg::ADDR_IRQ, v);
        check(v, 8'h04);
        wait_irq();
        rd(twm_pkg::ADDR_STAT, v);
        check(v, 8'h04);
        check(gotByte, 8'ha5);
        check({7'h00, wakeSeen}, 8'h00);
        check({7'h00, minHigh >= 8'h02}, 8'h01);
        rd(twm_pkg::ADDR_CTRL2, v);
        check(v & 8'h40, 8'h00);
        wr(twm_pkg::ADDR_STAT, 8'h00);
        rd(twm_pkg::ADDR_STAT, v);
        check(v, 8'h00);
        setup(1'b0, 1'b1, 8'h00, 8'h00);
        wr(twm_pkg::ADDR_BUF, 8'h3c);
        wr(twm_pkg::ADDR_CTRL2, 8'h08);
        wait_irq();
        rd(twm_pkg::ADDR_CTRL2, v);
        check(v & 8'h48, 8'h40);
        check(gotByte, 8'h3c);
        setup(1'b1, 1'b0, 8'h5a, 8'h03);
        wr(twm_pkg::ADDR_CTRL2, 8'h08);
        wr(twm_pkg::ADDR_BUF, 8'h11);
        wait_irq();
        check({7'h00, pins.sclOe}, 8'h01);
        rd(twm_pkg::ADDR_CTRL2, v);
        check(v & 8'h08, 8'h00);
        rd(twm_pkg::ADDR_STAT, v);
        check(v, 8'h05);
        rd(twm_pkg::ADDR_BUF, v);
        check(v, 8'h5a);
        rd(twm_pkg::ADDR_STAT, v);
        check(v, 8'h04);
        wr(twm_pkg::ADDR_STAT, 8'h00);
        wr(twm_pkg::ADDR_CTRL1, 8'h03);
        setup(1'b1, 1'b0, 8'hc3, 8'h00);
        wr(twm_pkg::ADDR_CTRL2, 8'h08);
        wait_irq();
        check({7'h00, wakeSeen}, 8'h01);
        setup(1'b1, 1'b0, 8'h96, 8'h00);
        wr(twm_pkg::ADDR_CTRL2, 8'h08);
        wait_irq();
        rd(twm_pkg::ADDR_STAT, v);
        check(v & 8'h03, 8'h03);
        wr(twm_pkg::ADDR_CTRL1, 8'h01);
        wr(twm_pkg::ADDR_CTRL2, 8'h10);
        wait_irq();
        check({7'h00, lastSda}, 8'h00);
        wr(twm_pkg::ADDR_CTRL2, 8'h30);
        wait_irq();
        check({7'h00, lastSda}, 8'h01);
        setup(1'b0, 1'b0, 8'h00, 8'h00);
        wr(twm_pkg::ADDR_BUF, 8'hff);
        repeat (5) @(posedge sys_clk);
        do_reset();
        #1 check({6'h00, pins.sclOe, pins.sdaOe}, 8'h00);
        rd(twm_pkg::ADDR_CTRL1, v);
        check(v, 8'h00);
        rd(twm_pkg::ADDR_STAT, v);
        check(v, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
